// file: hdl/aiss_code_check.sv
// Flags whether the selected multiplexer codes name a real input
`include "aiss_consts.svh"

module aiss_code_check (
    aiss_sel_if.check sel
);
    // Negative side: analog inputs, then references and grounds
    assign sel.neg_ok = (sel.neg_code <= `AISS_NEG_LAST_AIN) ||
        ((sel.neg_code >= `AISS_NEG_FIRST_REF) && (sel.neg_code <= `AISS_NEG_LAST_REF));
    // Positive side: inputs, buffered references, monitors
    assign sel.pos_ok = (sel.pos_code <= `AISS_POS_LAST_AIN) ||
        (sel.pos_code == `AISS_POS_BUF_B) || (sel.pos_code == `AISS_POS_BUF_A) ||
        ((sel.pos_code >= `AISS_POS_FIRST_MON) && (sel.pos_code <= `AISS_POS_LAST_MON));
endmodule // aiss_code_check

// file: hdl/aiss_consts.svh
// Offsets, field positions and reset values of the ADC input-select block
//
// Contract
// - The input-select register picks the converter inputs only while no sequence runs.
// - The negative input code is a 5-bit read/write field at bits 12:8, reset 0x11.
// - Negative codes 0x10 to 0x13 route the references and grounds; 0x11 suits single-ended use.
// - The positive input code is a 5-bit read/write field at bits 4:0 with 0xb/0xc buffered.
// - Positive codes 0x10 to 0x1b select monitors and references; 0x1c-0x1f are reserved.
// - Reset loads the input-select register with 0x00111f.
// - Writing 1 to control bit 31 while a sequence runs restarts it at the first channel.
// - Control bit 30 is a sequence enable resetting to zero; it reads back as the running state.
// - Writing 1 to the enable starts a sequence, again after each halt.
// - Mask bit n includes the channel whose positive code is n; a clear bit skips it.
`ifndef AISS_CONSTS_SVH
`define AISS_CONSTS_SVH

`define AISS_ADDR_INPUT_SELECT 32'h4008_6080
`define AISS_ADDR_SEQ_CONTROL 32'h4008_6088

`define AISS_NEG_MSB 12
`define AISS_NEG_LSB 8
`define AISS_POS_MSB 4
`define AISS_POS_LSB 0
`define AISS_NEG_RESET 5'h11
`define AISS_POS_RESET 5'h1f
`define AISS_INPUT_SELECT_RESET 32'h0000_111f
`define AISS_INPUT_SELECT_MASK 32'h0000_1f1f

`define AISS_RESTART_BIT 31
`define AISS_ENABLE_BIT 30
`define AISS_CHAN_COUNT 29
`define AISS_SEQ_CONTROL_RESET 32'h0000_0000

`define AISS_NEG_LAST_AIN 5'h09
`define AISS_NEG_FIRST_REF 5'h10
`define AISS_NEG_LAST_REF 5'h13
`define AISS_NEG_SEQ_CODE 5'h11
`define AISS_POS_LAST_AIN 5'h09
`define AISS_POS_BUF_B 5'h0b
`define AISS_POS_BUF_A 5'h0c
`define AISS_POS_FIRST_MON 5'h10
`define AISS_POS_LAST_MON 5'h1b

`define AISS_RESP_OKAY 2'h0
`define AISS_RESP_SLVERR 2'h2

`endif

// file: hdl/aiss_pkg.sv
// Types shared by the ADC input-select block
package aiss_pkg;
    typedef enum logic [0:0] {
        aiss_seq_idle,
        aiss_seq_run
    } aiss_seq_state_t;

    typedef logic [4:0] aiss_code_t;
endpackage

// file: hdl/aiss_sel_if.sv
// Carrier between the register logic and the code checker
interface aiss_sel_if;
    aiss_pkg::aiss_code_t pos_code;
    aiss_pkg::aiss_code_t neg_code;
    logic pos_ok;
    logic neg_ok;

    modport regs (output pos_code, output neg_code, input pos_ok, input neg_ok);
    modport check (input pos_code, input neg_code, output pos_ok, output neg_ok);
endinterface

// file: hdl/aiss_top.sv
// AXI4-Lite register slave driving the ADC input multiplexer codes and channel sequencer
`include "aiss_consts.svh"

module aiss_top #(
    parameter int CHAN_COUNT = `AISS_CHAN_COUNT
) (
    // Clock, reset, enable
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    // Write address channel
    input wire logic [31:0] awaddr,
    input wire logic [2:0] awprot,
    input wire logic awvalid,
    output logic awready,
    // Write data channel
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    // Write response channel
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // Read address channel
    input wire logic [31:0] araddr,
    input wire logic [2:0] arprot,
    input wire logic arvalid,
    output logic arready,
    // Read data channel
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // Converter side
    input wire logic conv_done,
    output aiss_pkg::aiss_code_t positive_input_code,
    output aiss_pkg::aiss_code_t negative_input_code,
    output logic positive_code_valid,
    output logic negative_code_valid,
    output logic seq_busy
);

    ////////////////////////////////////////////////////////////////////////////
    // Functions

    function automatic logic [31:0] merge_bytes(input logic [31:0] old_v,
            input logic [31:0] new_v, input logic [3:0] strb);
        logic [31:0] res;
        res = old_v;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return res;
    endfunction

    // Only the two register words answer OKAY; anything else gets SLVERR
    function automatic logic reg_mapped(input logic [31:0] addr);
        return (addr == `AISS_ADDR_INPUT_SELECT) || (addr == `AISS_ADDR_SEQ_CONTROL);
    endfunction

    // Lowest included channel at or above start; found flag in bit 5
    function automatic logic [5:0] first_channel(input logic [CHAN_COUNT-1:0] mask,
            input logic [5:0] start);
        logic [5:0] res;
        res = 6'h00;
        for (int i = CHAN_COUNT - 1; i >= 0; i--) begin
            if (mask[i] && (6'(i) >= start)) begin
                res = {1'b1, 5'(i)};
            end
        end
        return res;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // State

    logic [31:0] input_select;
    logic [CHAN_COUNT-1:0] chan_mask;
    aiss_pkg::aiss_seq_state_t seq_state;
    aiss_pkg::aiss_code_t seq_chan;
    logic wr_fire;
    logic rd_fire;

    aiss_sel_if sel ();

    aiss_code_check u_check (
        .sel(sel)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Bus decoding

    wire logic hit_wr_sel = (awaddr == `AISS_ADDR_INPUT_SELECT);
    wire logic hit_wr_seq = (awaddr == `AISS_ADDR_SEQ_CONTROL);
    wire logic hit_rd_sel = (araddr == `AISS_ADDR_INPUT_SELECT);
    wire logic hit_rd_seq = (araddr == `AISS_ADDR_SEQ_CONTROL);
    wire logic wr_take = awvalid && wvalid && !awready && !bvalid;
    wire logic rd_take = arvalid && !arready && !rvalid;
    wire logic [1:0] wr_resp = reg_mapped(awaddr) ? `AISS_RESP_OKAY : `AISS_RESP_SLVERR;
    wire logic [1:0] rd_resp = reg_mapped(araddr) ? `AISS_RESP_OKAY : `AISS_RESP_SLVERR;
    wire logic [31:0] seq_image = {2'h0, 1'b0, chan_mask};
    wire logic [31:0] seq_merged = merge_bytes(seq_image, wdata, wstrb);
    wire logic [31:0] sel_merged = merge_bytes(input_select, wdata, wstrb)
        & `AISS_INPUT_SELECT_MASK;
    wire logic sel_wr = wr_fire && hit_wr_sel;
    wire logic seq_wr = wr_fire && hit_wr_seq;
    wire logic enable_req = seq_wr && seq_merged[`AISS_ENABLE_BIT];
    wire logic restart_req = seq_wr && seq_merged[`AISS_RESTART_BIT];
    wire logic jump_first = restart_req || enable_req;
    wire logic [CHAN_COUNT-1:0] live_mask = seq_wr ? seq_merged[CHAN_COUNT-1:0] : chan_mask;
    // Enable reads back as the running state, restart always as zero
    wire logic [31:0] rd_value = hit_rd_sel ? input_select :
        hit_rd_seq ? {1'b0, seq_state == aiss_pkg::aiss_seq_run, 1'b0, chan_mask} :
        32'h0000_0000;
    // Register fields as the multiplexers see them outside a sequence
    wire aiss_pkg::aiss_code_t reg_pos_code = input_select[`AISS_POS_MSB:`AISS_POS_LSB];
    wire aiss_pkg::aiss_code_t reg_neg_code = input_select[`AISS_NEG_MSB:`AISS_NEG_LSB];

    ////////////////////////////////////////////////////////////////////////////
    // Sequencer decisions

    wire logic [5:0] first_hit = first_channel(live_mask, 6'h00);
    wire logic [5:0] next_hit = first_channel(chan_mask, {1'b0, seq_chan} + 6'h01);
    wire logic seq_running = (seq_state == aiss_pkg::aiss_seq_run);
    aiss_pkg::aiss_seq_state_t next_seq_state;
    aiss_pkg::aiss_code_t next_seq_chan;

    always_comb begin
        next_seq_state = seq_state;
        next_seq_chan = seq_chan;
        case (seq_state)
            aiss_pkg::aiss_seq_idle: begin
                if (enable_req && first_hit[5]) begin
                    next_seq_state = aiss_pkg::aiss_seq_run;
                    next_seq_chan = first_hit[4:0];
                end
            end
            aiss_pkg::aiss_seq_run: begin
                // Restart beats a conversion finishing in the same cycle
                if (jump_first) begin
                    if (first_hit[5]) begin
                        next_seq_chan = first_hit[4:0];
                    end else begin
                        next_seq_state = aiss_pkg::aiss_seq_idle;
                    end
                end else if (conv_done) begin
                    if (next_hit[5]) begin
                        next_seq_chan = next_hit[4:0];
                    end else begin
                        // Halt after one pass; software re-enables for another
                        next_seq_state = aiss_pkg::aiss_seq_idle;
                    end
                end
            end
            default: begin
                next_seq_state = aiss_pkg::aiss_seq_idle;
            end
        endcase
    end

    // Sequencer owns the positive input while running, register otherwise
    assign sel.pos_code = seq_running ? seq_chan : reg_pos_code;
    assign sel.neg_code = seq_running ? `AISS_NEG_SEQ_CODE : reg_neg_code;

    ////////////////////////////////////////////////////////////////////////////
    // Write channel

    // Address and data are taken together; a lone channel waits for its partner
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready <= 1'b0;
            wready <= 1'b0;
        end else if (ce) begin
            awready <= wr_take;
            wready <= wr_take;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wr_fire <= 1'b0;
        end else if (ce) begin
            wr_fire <= wr_take;
        end
    end

    // Response stands until the master takes it; no second write meanwhile
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid <= 1'b0;
        end else if (ce) begin
            if (wr_fire) begin
                bvalid <= 1'b1;
            end else if (bready) begin
                bvalid <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bresp <= `AISS_RESP_OKAY;
        end else if (ce && wr_fire) begin
            bresp <= wr_resp;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read channel

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready <= 1'b0;
        end else if (ce) begin
            arready <= rd_take;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rd_fire <= 1'b0;
        end else if (ce) begin
            rd_fire <= rd_take;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid <= 1'b0;
        end else if (ce) begin
            if (rd_fire) begin
                rvalid <= 1'b1;
            end else if (rready) begin
                rvalid <= 1'b0;
            end
        end
    end

    // Data and code are loaded once and held with rvalid
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rdata <= 32'h0000_0000;
            rresp <= `AISS_RESP_OKAY;
        end else if (ce && rd_fire) begin
            rdata <= rd_value;
            rresp <= rd_resp;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Registers

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            input_select <= `AISS_INPUT_SELECT_RESET;
        end else if (ce && sel_wr) begin
            input_select <= sel_merged;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            chan_mask <= CHAN_COUNT'(`AISS_SEQ_CONTROL_RESET);
        end else if (ce && seq_wr) begin
            chan_mask <= seq_merged[CHAN_COUNT-1:0];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            seq_state <= aiss_pkg::aiss_seq_idle;
            seq_chan <= 5'h00;
        end else if (ce) begin
            seq_state <= next_seq_state;
            seq_chan <= next_seq_chan;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Converter-side outputs, registered

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            positive_input_code <= `AISS_POS_RESET;
            negative_input_code <= `AISS_NEG_RESET;
        end else if (ce) begin
            positive_input_code <= sel.pos_code;
            negative_input_code <= sel.neg_code;
        end
    end

    // Reserved codes flagged rather than blocked; software must avoid them
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            positive_code_valid <= 1'b0;
            negative_code_valid <= 1'b1;
        end else if (ce) begin
            positive_code_valid <= sel.pos_ok;
            negative_code_valid <= sel.neg_ok;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            seq_busy <= 1'b0;
        end else if (ce) begin
            seq_busy <= seq_running;
        end
    end

endmodule // aiss_top

// file: verif/aiss_top_properties.sv
// Port-level checker of the ADC input-select register block
module aiss_top_chk #(
    parameter int CHAN_COUNT = 29
) (
    // Clock, reset, enable
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    // Register bus
    input wire logic awvalid,
    input wire logic wvalid,
    input wire logic awready,
    input wire logic wready,
    input wire logic bvalid,
    input wire logic bready,
    input wire logic arvalid,
    input wire logic arready,
    input wire logic rvalid,
    input wire logic [31:0] rdata,
    // Converter side
    input wire aiss_pkg::aiss_code_t positive_input_code,
    input wire aiss_pkg::aiss_code_t negative_input_code,
    input wire logic positive_code_valid,
    input wire logic negative_code_valid,
    input wire logic seq_busy
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);

    ////////////////////////////////////////////////////////////////////////////
    AST_RST_VAL: assert property (
        $rose(aresetn) |-> positive_input_code == 5'h1f && negative_input_code == 5'h11
            && !seq_busy) else $error("outputs not at reset value");
    AST_NEG_SEQ: assert property (
        seq_busy |-> negative_input_code == 5'h11) else $error("negative code not forced");
    AST_NEG_OK: assert property (
        negative_code_valid == (negative_input_code <= 5'h09
            || (negative_input_code >= 5'h10 && negative_input_code <= 5'h13)))
        else $error("negative code flag wrong");
    AST_POS_OK: assert property (
        positive_code_valid == (positive_input_code <= 5'h09 || positive_input_code == 5'h0b
            || positive_input_code == 5'h0c
            || (positive_input_code >= 5'h10 && positive_input_code <= 5'h1b)))
        else $error("positive code flag wrong");
    AST_WR_TAKE: assert property (
        awvalid && wvalid && !awready && !bvalid && ce |=> awready && wready ##1 bvalid)
        else $error("write not answered in time");
    AST_RD_TAKE: assert property (
        arvalid && !arready && !rvalid && ce |=> arready ##1 rvalid)
        else $error("read not answered in time");
    AST_B_DROP: assert property (
        bvalid && bready && ce |=> !bvalid) else $error("write response held too long");
    AST_R_BIT31: assert property (
        rvalid |-> !rdata[31]) else $error("restart bit read as one");
    AST_CE_HOLD: assert property (
        !ce |=> $stable(positive_input_code) && $stable(negative_input_code) && $stable(seq_busy))
        else $error("outputs moved while clock enable was low");
endmodule // aiss_top_chk

bind aiss_top aiss_top_chk #(.CHAN_COUNT(CHAN_COUNT)) u_chk (
    .aclk(aclk), .aresetn(aresetn), .ce(ce), .awvalid(awvalid), .wvalid(wvalid),
    .awready(awready), .wready(wready), .bvalid(bvalid), .bready(bready),
    .arvalid(arvalid), .arready(arready), .rvalid(rvalid), .rdata(rdata),
    .positive_input_code(positive_input_code), .negative_input_code(negative_input_code),
    .positive_code_valid(positive_code_valid), .negative_code_valid(negative_code_valid),
    .seq_busy(seq_busy)
);

// file: verif/tb.sv
// Self-checking bench of the ADC input-select register block
`include "aiss_consts.svh"
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {logic [31:0] wd; logic pv; logic nv;} aiss_row_t;
    localparam logic [31:0] a_sel = `AISS_ADDR_INPUT_SELECT;
    localparam logic [31:0] a_seq = `AISS_ADDR_SEQ_CONTROL;
    logic aclk, aresetn, ce, awvalid, wvalid, bready, arvalid, rready, conv_done;
    logic awready, wready, bvalid, arready, rvalid, pv, nv, busy;
    logic [31:0] awaddr, wdata, araddr, rdata, rd;
    logic [2:0] awprot, arprot;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, rs;
    aiss_pkg::aiss_code_t pos, neg;
    int n_fail = 0;
    int compares = 0;
    int cyc = 0;
    aiss_row_t rows [9] = '{'{32'h0000_ffff, 1'b0, 1'b0}, '{32'h0000_0900, 1'b1, 1'b1},
        '{32'h0000_0a0a, 1'b0, 1'b0}, '{32'h0000_130b, 1'b1, 1'b1},
        '{32'h0000_100c, 1'b1, 1'b1}, '{32'h0000_140d, 1'b0, 1'b0},
        '{32'h0000_0f10, 1'b1, 1'b0}, '{32'h0000_121b, 1'b1, 1'b1},
        '{32'h0000_111c, 1'b0, 1'b1}};

    initial begin
        aclk = 1'b0;
        forever #20 aclk = ~aclk;
    end

    aiss_top u_dut (.aclk(aclk), .aresetn(aresetn), .ce(ce), .awaddr(awaddr), .awprot(awprot),
        .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
        .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
        .arprot(arprot), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
        .rvalid(rvalid), .rready(rready), .conv_done(conv_done), .positive_input_code(pos),
        .negative_input_code(neg), .positive_code_valid(pv), .negative_code_valid(nv),
        .seq_busy(busy));

    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask

    task automatic axw(input logic [31:0] a, input logic [31:0] d);
        logic aw_done, w_done;
        aw_done = 1'b0;
        w_done = 1'b0;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            aw_done = aw_done || awready === 1'b1;
            w_done = w_done || wready === 1'b1;
            if (aw_done) awvalid <= 1'b0;
            if (w_done) wvalid <= 1'b0;
        end while (!(aw_done && w_done));
        do @(posedge aclk); while (bvalid !== 1'b1);
        rs = bresp;
        bready <= 1'b0;
        repeat (2) @(posedge aclk);
    endtask

    task automatic axr(input logic [31:0] a);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge aclk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge aclk); while (rvalid !== 1'b1);
        rd = rdata;
        rs = rresp;
        rready <= 1'b0;
    endtask

    task automatic pulse();
        @(posedge aclk);
        conv_done <= 1'b1;
        @(posedge aclk);
        conv_done <= 1'b0;
        repeat (2) @(posedge aclk);
    endtask

    task automatic results();
        $display("compares %0d, mismatches %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // Hang guard, far above the few hundred cycles the whole test needs
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_fail++;
            results();
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready, conv_done} = 7'h00;
        {awaddr, wdata, araddr, awprot, arprot} = '0;
        ce = 1'b1;
        wstrb = 4'hf;
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        chk({pos, neg, pv, nv, busy}, {5'h1f, 5'h11, 1'b0, 1'b1, 1'b0});
        axr(a_sel);
        chk(rd, 32'h0000_111f);
        axr(a_seq);
        chk(rd, 32'h0000_0000);
        $display("reset test done");
        foreach (rows[i]) begin
            axw(a_sel, rows[i].wd);
            chk({30'h0, rs}, 32'h0000_0000);
            chk({pos, neg, pv, nv},
                {rows[i].wd[4:0], rows[i].wd[12:8], rows[i].pv, rows[i].nv});
            axr(a_sel);
            chk({30'h0, rs}, 32'h0000_0000);
            chk(rd, rows[i].wd & 32'h0000_1f1f);
        end
        $display("table test done");
        axw(32'h4008_6084, 32'h0000_0001);
        chk({30'h0, rs}, 32'h2);
        axr(32'h4008_6084);
        chk({rd[29:0], rs}, 32'h2);
        $display("unmapped test done");
        axw(a_sel, 32'h0000_0502);
        axw(a_seq, 32'h4040_0028);
        chk({pos, neg, pv, nv, busy}, {5'h03, 5'h11, 3'h7});
        axr(a_seq);
        chk(rd, 32'h4040_0028);
        pulse();
        chk({27'h0, pos}, 32'h05);
        axw(a_seq, 32'h8040_0028);
        chk({27'h0, pos}, 32'h03);
        axr(a_seq);
        chk(rd, 32'h4040_0028);
        pulse();
        pulse();
        chk({pos, neg, pv, nv, busy}, {5'h16, 5'h11, 3'h7});
        pulse();
        chk({pos, neg, pv, nv, busy}, {5'h02, 5'h05, 3'h6});
        axw(a_seq, 32'h8000_0001);
        chk({31'h0, busy}, 32'h0);
        axw(a_seq, 32'h4000_0001);
        chk({pos, neg, pv, nv, busy}, {5'h00, 5'h11, 3'h7});
        $display("sequencer test done");
        ce <= 1'b0;
        pulse();
        chk({pos, busy}, {5'h00, 1'b1});
        ce <= 1'b1;
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        chk({pos, neg, pv, nv, busy}, {5'h1f, 5'h11, 1'b0, 1'b1, 1'b0});
        axr(a_sel);
        chk(rd, 32'h0000_111f);
        axr(a_seq);
        chk(rd, 32'h0000_0000);
        $display("freeze and reset rerun done");
        results();
    end
endmodule // tb
